// >>> src/ppip_lowqual.sv
// module: qualifies an active-low pin held low for a minimum count
`default_nettype none
module ppip_lowqual #(
   parameter logic [ppip_pkg::CNT_W-1:0] MIN_CYC = 16'h0005
) (
   input  wire logic   ref_clk,
   input  wire logic   reset,
   ppip_qual_if.filt   q
);
   logic [ppip_pkg::CNT_W-1:0] run;       // consecutive low samples, saturating
   wire                         at_min = (run >= MIN_CYC);

   // short glitches restart the count, so noise never reads as a pulse
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         run <= '0;
      end else if (q.raw_n) begin
         run <= '0;
      end else if (!at_min) begin
         run <= run + 1'b1;
      end
   end

   assign q.held = at_min;
endmodule
`default_nettype wire

// >>> src/ppip_pkg.sv
// package: constants, register map and states for the parallel input port
//
// Summary of operation
// - latch high is idle, low takes byte
// - eight data lines, first line is bit 1
// - data high means one, low means zero
// - acknowledge pulse low about 5 us
// - busy high while taking, printing, offline, faulted
// - paper-out flag high while paper absent
// - selected flag shows on-line state
// - auto feed request low: line advance after line
// - board switch forces auto feed active
// - init low over 50 us resets, clears buffer
// - fault output low on paper-out, offline, error
// - data accepted only while entry enable low or entry switch set
`default_nettype none
package ppip_pkg;
   // clock and documented times
   localparam int CLK_PERIOD_NS  = 100;
   localparam int LATCH_MIN_NS   = 500;
   localparam int ACK_PULSE_NS   = 5000;
   localparam int INIT_MIN_NS    = 50000;
   // least times round up, the acknowledge width rounds down
   localparam int LATCH_MIN_CYC  = (LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_PULSE_CYC  = ACK_PULSE_NS / CLK_PERIOD_NS;
   localparam int INIT_MIN_CYC   = (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W          = 16;

   // register bus
   localparam int ADDR_W         = 8;
   localparam int DATA_W         = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RXDATA   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h10;

   // control fields
   localparam int CTRL_ONLINE    = 0;
   localparam int CTRL_W         = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h1;

   // status fields
   localparam int ST_BUSY        = 0;
   localparam int ST_PAPER_OUT   = 1;
   localparam int ST_ONLINE      = 2;
   localparam int ST_FAULT       = 3;
   localparam int ST_ENTRY_OK    = 4;
   localparam int ST_LF_ACTIVE   = 5;
   localparam int ST_W           = 6;

   // interrupt events
   localparam int EV_BYTE        = 0;
   localparam int EV_INIT        = 1;
   localparam int EV_PAPER       = 2;
   localparam int EV_FAULT       = 3;
   localparam int EV_W           = 4;
   localparam logic [EV_W-1:0] EV_RESET = 4'h0;

   typedef enum logic [1:0] {PPIP_IDLE, PPIP_WAIT_RISE, PPIP_ACK} ppip_state_t;
endpackage
`default_nettype wire

// >>> src/ppip_qual_if.sv
// interface: one active-low pin and its qualified low-hold flag
`default_nettype none
interface ppip_qual_if;
   logic raw_n;   // pin level, low active
   logic held;    // pin has stayed low for the minimum count
   modport filt (input raw_n, output held);
   modport user (output raw_n, input held);
endinterface
`default_nettype wire

// >>> src/ppip_top.sv
// module: receive side of the byte-wide parallel printer input port
//
// Local design decisions: the register addresses and the strobed register port.
`default_nettype none
module ppip_top #(
   parameter logic [ppip_pkg::CNT_W-1:0] LATCH_MIN = ppip_pkg::CNT_W'(ppip_pkg::LATCH_MIN_CYC),
   parameter logic [ppip_pkg::CNT_W-1:0] ACK_CYC   = ppip_pkg::CNT_W'(ppip_pkg::ACK_PULSE_CYC),
   parameter logic [ppip_pkg::CNT_W-1:0] INIT_MIN  = ppip_pkg::CNT_W'(ppip_pkg::INIT_MIN_CYC)
) (
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   // host side pins
   input  wire logic [7:0]                    data_in,
   input  wire logic                          latch_n,
   input  wire logic                          init_n,
   input  wire logic                          auto_line_advance_req_n,
   input  wire logic                          entry_enable_in_n,
   output logic                               byte_taken_pulse_n,
   output logic                               busy,
   output logic                               paper_out_flag,
   output logic                               online_selected_flag,
   output logic                               fault_n,
   // board switches
   input  wire logic                          sw_auto_lf_force,
   input  wire logic                          sw_entry_force,
   // printer mechanism and controller side
   input  wire logic                          paper_absent,
   input  wire logic                          mech_error,
   input  wire logic                          printing,
   input  wire logic                          line_done,
   output logic [7:0]                         rx_byte,
   output logic                               rx_valid,
   output logic                               line_advance,
   output logic                               buf_clear,
   // register port
   input  wire logic [ppip_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [ppip_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [ppip_pkg::DATA_W-1:0]        reg_rdata,
   output logic                               irq
);
   ////////////////////////////////////////////////////////////////////////////
   // pin qualifiers
   // the host pins carry no clock of their own, so each strobe is believed only
   // after it has stayed low for a whole count; a spike on a long cable then
   // cannot start a transfer or wipe the buffer; the price is a few cycles of
   // extra latency on every byte
   ppip_qual_if latch_q ();                     // latch pulse qualifier
   ppip_qual_if init_q ();                      // init pulse qualifier
   assign latch_q.raw_n = latch_n;
   assign init_q.raw_n  = init_n;

   // one qualifier per strobe pin, each with its own minimum count
   ppip_lowqual #(.MIN_CYC(LATCH_MIN)) u_latch (
      .ref_clk (ref_clk),
      .reset   (reset),
      .q       (latch_q)
   );
   ppip_lowqual #(.MIN_CYC(INIT_MIN)) u_init (
      .ref_clk (ref_clk),
      .reset   (reset),
      .q       (init_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state and registers
   // registers reset to an idle, on-line port; busy stays high only while
   // reset itself is applied and follows ready from the first edge after it
   typedef ppip_pkg::ppip_state_t       ppip_st_t;      // local name of the handshake state
   ppip_st_t                            state;          // handshake state
   ppip_st_t                            next_state;     // state after this edge
   logic [ppip_pkg::CNT_W-1:0]          ack_cnt;        // acknowledge width counter
   logic [ppip_pkg::CTRL_W-1:0]         ctrl;           // software control
   logic [ppip_pkg::EV_W-1:0]           int_stat;       // sticky events
   logic [ppip_pkg::EV_W-1:0]           int_mask;       // event enables
   logic                                init_seen;      // init qualified last cycle
   logic                                paper_prev;     // paper sensor last cycle
   logic                                err_prev;       // mechanism error last cycle

   // combinational conditions
   // ready gathers every reason to refuse a byte; busy is driven from it so the
   // host sees one level, and a latch that arrives while not ready is simply
   // ignored rather than queued, since there is no buffer behind the port;
   // a host that ignores busy therefore loses bytes
   wire online     = ctrl[ppip_pkg::CTRL_ONLINE];
   wire entry_ok   = !entry_enable_in_n || sw_entry_force;
   wire lf_active  = !auto_line_advance_req_n || sw_auto_lf_force;
   wire fault_cond = paper_absent || mech_error || !online;
   wire ready      = online && entry_ok && !printing && !paper_absent && !mech_error && !init_q.held;
   wire take       = (state == ppip_pkg::PPIP_IDLE) && latch_q.held && ready;
   wire init_rise  = init_q.held && !init_seen;
   wire ack_done   = (ack_cnt == ACK_CYC - 1'b1);
   wire next_busy  = take || (next_state != ppip_pkg::PPIP_IDLE) || !ready;

   // events for the interrupt status
   // edges only, so a paper or mechanism fault that persists is reported once
   wire [ppip_pkg::EV_W-1:0] ev = {mech_error && !err_prev, paper_absent && !paper_prev, init_rise, take};

   // register decode
   // unmapped addresses read as zero and ignore writes; status and receive data
   // are read-only views, so a stray write there cannot disturb the handshake
   wire sel_ctrl = (reg_addr == ppip_pkg::REG_CTRL);
   wire sel_st   = (reg_addr == ppip_pkg::REG_STATUS);
   wire sel_rx   = (reg_addr == ppip_pkg::REG_RXDATA);
   wire sel_is   = (reg_addr == ppip_pkg::REG_INT_STAT);
   wire sel_im   = (reg_addr == ppip_pkg::REG_INT_MASK);
   // write-one-to-clear mask for the sticky status
   wire [ppip_pkg::EV_W-1:0] w1c = (reg_wr && sel_is) ? reg_wdata[ppip_pkg::EV_W-1:0] : '0;
   // set wins over clear so no event slips past a clearing write
   wire [ppip_pkg::EV_W-1:0] next_int_stat = (int_stat & ~w1c) | ev;

   // status word shows the host pins as the host sees them, fault as active high
   wire [ppip_pkg::ST_W-1:0] status_word = {lf_active, entry_ok, !fault_n, online_selected_flag,
                                            paper_out_flag, busy};
   // read mux stays continuous so the register flip-flop block below stays short
   wire [ppip_pkg::DATA_W-1:0] next_rdata =
        sel_ctrl ? ppip_pkg::DATA_W'(ctrl) :
        sel_st   ? ppip_pkg::DATA_W'(status_word) :
        sel_rx   ? ppip_pkg::DATA_W'(rx_byte) :
        sel_is   ? ppip_pkg::DATA_W'(int_stat) :
        sel_im   ? ppip_pkg::DATA_W'(int_mask) : '0;

   ////////////////////////////////////////////////////////////////////////////
   // handshake sequencing
   // idle, then byte taken on a qualified latch, then wait for the latch to go
   // high, then acknowledge for a fixed count, then idle; init forces idle from
   // anywhere, which may cut an acknowledge short, as the host asked for a restart
   always_comb begin
      next_state = state;
      unique case (state)
         ppip_pkg::PPIP_IDLE: begin
            if (take) begin
               next_state = ppip_pkg::PPIP_WAIT_RISE;
            end
         end
         // wait for latch release so a long pulse is taken only once
         ppip_pkg::PPIP_WAIT_RISE: begin
            if (latch_n) begin
               next_state = ppip_pkg::PPIP_ACK;
            end
         end
         ppip_pkg::PPIP_ACK: begin
            if (ack_done) begin
               next_state = ppip_pkg::PPIP_IDLE;
            end
         end
      endcase
      if (init_rise) begin
         next_state = ppip_pkg::PPIP_IDLE;
      end
   end

   // state register and acknowledge counter
   // the counter runs only inside the acknowledge, so each pulse starts from zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state   <= ppip_pkg::PPIP_IDLE;
         ack_cnt <= '0;
      end else begin
         state   <= next_state;
         ack_cnt <= (state == ppip_pkg::PPIP_ACK && next_state == ppip_pkg::PPIP_ACK) ? ack_cnt + 1'b1 : '0;
      end
   end

   // byte capture, bit 1 in lane 0, high is one
   // the byte is held until the next take, so the controller may read it late
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rx_byte  <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= take;
         if (take) begin
            rx_byte <= data_in;
         end
      end
   end

   // host-facing outputs from flip-flops
   // registering these costs one cycle of latency but keeps the pins free of
   // decode glitches, which a host sampling without our clock would otherwise
   // see as false acknowledges
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         busy                 <= 1'b1;
         byte_taken_pulse_n   <= 1'b1;
         paper_out_flag       <= 1'b0;
         online_selected_flag <= 1'b0;
         fault_n              <= 1'b1;
      end else begin
         busy                 <= next_busy;
         byte_taken_pulse_n   <= !(next_state == ppip_pkg::PPIP_ACK);
         paper_out_flag       <= paper_absent;
         online_selected_flag <= online;
         fault_n              <= !fault_cond;
      end
   end

   // line advance and buffer clear pulses
   // buf_clear is a one-cycle pulse per init; line_advance stays high for as long as line_done does while auto feed is active
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         line_advance <= 1'b0;
         buf_clear    <= 1'b0;
         init_seen    <= 1'b0;
      end else begin
         line_advance <= line_done && lf_active;
         buf_clear    <= init_rise;
         init_seen    <= init_q.held;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file and interrupt
   // status bits are sticky and cleared by writing a one; the interrupt is a
   // registered level, so it lags a mask write by one cycle; software that
   // unmasks and then polls irq at once must allow for that cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl       <= ppip_pkg::CTRL_RESET;
         int_mask   <= ppip_pkg::EV_RESET;
         int_stat   <= ppip_pkg::EV_RESET;
         reg_rdata  <= '0;
         paper_prev <= 1'b0;
         err_prev   <= 1'b0;
         irq        <= 1'b0;
      end else begin
         if (reg_wr && sel_ctrl) begin
            ctrl <= reg_wdata[ppip_pkg::CTRL_W-1:0];
         end
         if (reg_wr && sel_im) begin
            int_mask <= reg_wdata[ppip_pkg::EV_W-1:0];
         end
         int_stat   <= next_int_stat;
         reg_rdata  <= reg_rd ? next_rdata : '0;
         paper_prev <= paper_absent;
         err_prev   <= mech_error;
         irq        <= |(next_int_stat & int_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // all checks use the single port clock and are silenced while reset is high;
   // widths are checked in cycles, so they follow the parameters
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // length of the current acknowledge, for the width check
   logic [ppip_pkg::CNT_W-1:0] ack_run;    // cycles the acknowledge has been low
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ack_run <= '0;
      end else begin
         ack_run <= byte_taken_pulse_n ? '0 : ack_run + 1'b1;
      end
   end

   a_busy_on_take:   assert property (take |=> busy)
      else $error("busy not raised after byte taken");
   a_busy_thru_ack:  assert property (!byte_taken_pulse_n |-> busy)
      else $error("busy dropped during acknowledge");
   a_ack_pulse_len:  assert property ($rose(byte_taken_pulse_n) |-> ack_run == ACK_CYC)
      else $error("acknowledge width wrong");
   a_byte_capture:   assert property (take |=> rx_valid && rx_byte == $past(data_in))
      else $error("byte not captured from data lines");
   a_busy_offline:   assert property (!online |=> busy && !fault_n)
      else $error("offline without busy and fault");
   a_paper_fault:    assert property (paper_absent |=> paper_out_flag && !fault_n)
      else $error("paper out not reported");
   a_auto_advance:   assert property (line_done && lf_active |=> line_advance)
      else $error("line advance missing");
   a_no_advance:     assert property (line_done && !lf_active |=> !line_advance)
      else $error("line advance without request");
   a_init_clear:     assert property (init_rise |=> buf_clear && state == ppip_pkg::PPIP_IDLE)
      else $error("init did not reset port");
   a_entry_gate:     assert property (!entry_ok |-> !take)
      else $error("byte taken while entry disabled");
   // level checks on the printing, mechanism and init causes and on the status pins, then auto feed, acknowledge order and byte hold
   a_busy_printing:  assert property (printing |=> busy)
      else $error("busy low while printing");
   a_busy_mech:      assert property (mech_error |=> busy && !fault_n)
      else $error("mechanism error without busy and fault");
   a_busy_init:      assert property (init_q.held |=> busy)
      else $error("busy low while init held");
   a_busy_release:   assert property (state == ppip_pkg::PPIP_IDLE && ready && !take |=> !busy)
      else $error("busy high while ready");
   a_paper_clear:    assert property (!paper_absent |=> !paper_out_flag)
      else $error("paper out shown with paper present");
   a_online_flag:    assert property (online |=> online_selected_flag)
      else $error("selected flag low while on-line");
   a_fault_clear:    assert property (!fault_cond |=> fault_n)
      else $error("fault shown without cause");
   a_lf_switch:      assert property (line_done && sw_auto_lf_force |=> line_advance)
      else $error("forced auto feed ignored");
   a_ack_after_rel:  assert property ($fell(byte_taken_pulse_n) |-> $past(state) == ppip_pkg::PPIP_WAIT_RISE)
      else $error("acknowledge without a taken byte");
   a_rx_stable:      assert property (!take |=> $stable(rx_byte))
      else $error("received byte changed without a take");

   // scenarios worth seeing at least once
   c_byte_done:      cover property (take ##[1:200] $rose(byte_taken_pulse_n));
   c_init_reset:     cover property (init_rise);
   c_auto_advance:   cover property (line_done && lf_active);
   c_irq_raise:      cover property ($rose(irq));
   c_entry_forced:   cover property (take && entry_enable_in_n);
endmodule
`default_nettype wire

// >>> tb/ppip_host_model.sv
// host model: drives the byte lanes and the latch of the parallel port
`default_nettype none
module ppip_host_model (
   input  wire logic       ref_clk,
   input  wire logic       busy,
   output logic [7:0]      data_in,
   output logic            latch_n
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////
   // idle: latch high, lanes at zero
   initial begin
      data_in = 8'h00;
      latch_n = 1'b1;
   end
   // one byte: wait for ready, hold latch low for hold edges, release
   task automatic send(input logic [7:0] b, input int hold);
      int n;
      n = 0;
      @(posedge ref_clk);
      // bounded wait, so a stuck busy cannot hang the run
      while (busy !== 1'b0 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      // a port that never turns ready gets no byte; the missing byte shows as a mismatch
      if (n >= 300) return;
      data_in <= b;
      latch_n <= 1'b0;
      repeat (hold) @(posedge ref_clk);
      latch_n <= 1'b1;
      @(posedge ref_clk);
      // lanes released: show the inverse, never a stale copy of the byte
      data_in <= ~b;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// testbench: host transfers, status pins, auto feed, init and registers
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LATCH = 4;   // shortened latch qualify count
   localparam int ACK   = 8;   // shortened acknowledge width
   localparam int INIT  = 8;   // shortened init qualify count
   logic ref_clk, reset, latch_n, init_n, auto_line_advance_req_n, entry_enable_in_n;
   logic sw_auto_lf_force, sw_entry_force, paper_absent, mech_error, printing, line_done;
   logic byte_taken_pulse_n, busy, paper_out_flag, online_selected_flag, fault_n;
   logic rx_valid, line_advance, buf_clear, irq, reg_wr, reg_rd;
   logic [7:0] data_in, rx_byte, last_rx;
   logic [ppip_pkg::ADDR_W-1:0] reg_addr;
   logic [ppip_pkg::DATA_W-1:0] reg_wdata, reg_rdata, rv;
   logic [7:0] pat [4] = '{8'ha5, 8'h01, 8'h80, 8'h5a};   // walking ends of the lanes
   int n_fail, checks, cyc, n_rx, n_adv, n_clr, ack_run, ack_len, bad_busy, k0;
   ////////////////////////////////////////////////////////////////
   ppip_top #(.LATCH_MIN(16'h0004), .ACK_CYC(16'h0008), .INIT_MIN(16'h0008)) ppip_top_inst (
      .ref_clk, .reset, .data_in, .latch_n, .init_n, .auto_line_advance_req_n,
      .entry_enable_in_n, .byte_taken_pulse_n, .busy, .paper_out_flag, .online_selected_flag,
      .fault_n, .sw_auto_lf_force, .sw_entry_force, .paper_absent, .mech_error, .printing,
      .line_done, .rx_byte, .rx_valid, .line_advance, .buf_clear, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .irq);
   ppip_host_model ppip_host_model_inst (.ref_clk, .busy, .data_in, .latch_n);
   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////
   // monitor: counts pulses, measures acknowledge width, cuts hangs
   always @(posedge ref_clk) begin
      cyc++;
      if (rx_valid === 1'b1) begin
         n_rx++;
         last_rx = rx_byte;
      end
      if (line_advance === 1'b1) n_adv++;
      if (buf_clear === 1'b1) n_clr++;
      if (byte_taken_pulse_n === 1'b0) begin
         ack_run++;
         if (busy !== 1'b1) bad_busy++;
      end else if (ack_run != 0) begin
         ack_len = ack_run;
         ack_run = 0;
      end
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // wait n edges, then let their updates settle
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask
   task automatic xfer(input logic [7:0] b);
      ppip_host_model_inst.send(b, LATCH + 2);
      tick(ACK + 6);
   endtask
   // one not-ready cause at a time
   task automatic cond(input int i, input logic v);
      @(posedge ref_clk);
      case (i)
         0: printing <= v;
         1: paper_absent <= v;
         2: mech_error <= v;
         3: wr(ppip_pkg::REG_CTRL, {31'h0, ~v});
         default: entry_enable_in_n <= v;
      endcase
   endtask
   task automatic summarize();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      {ref_clk, auto_line_advance_req_n, entry_enable_in_n} = 3'h0; // latch belongs to the host model
      {sw_auto_lf_force, sw_entry_force, paper_absent, mech_error, printing} = 5'h00;
      {line_done, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {n_fail, checks, cyc, n_rx, n_adv, n_clr, ack_run, ack_len, bad_busy} = '0;
      reset = 1'b1;
      init_n = 1'b1;
      auto_line_advance_req_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      tick(2);
      chk("ack_idle", 1, byte_taken_pulse_n);
      chk("busy_ready", 0, busy);
      chk("online", 1, online_selected_flag);
      chk("fault_n", 1, fault_n);
      rd(ppip_pkg::REG_CTRL);
      chk("ctrl", 32'h1, rv);
      rd(8'h40);
      chk("unmapped", 32'h0, rv);
      wr(ppip_pkg::REG_INT_MASK, 32'h1 << ppip_pkg::EV_BYTE);
      foreach (pat[k]) begin
         xfer(pat[k]);
         chk("rx_byte", pat[k], last_rx);
         chk("ack_len", ACK, ack_len);
         chk("busy_in_ack", 0, bad_busy);
      end
      chk("irq_set", 1, irq);
      wr(ppip_pkg::REG_INT_STAT, 32'h1);
      tick(2);
      chk("irq_clear", 0, irq);
      // a latch too short to qualify must be ignored
      ppip_host_model_inst.send(8'h3c, LATCH - 2);
      tick(ACK + 6);
      chk("short_latch", 4, n_rx);
      for (int i = 0; i < 5; i++) begin
         cond(i, 1'b1);
         tick(3);
         chk("busy_cause", 1, busy);
         chk("fault_n", i == 0 || i == 4, fault_n);
         chk("paper_out", i == 1, paper_out_flag);
         chk("online", i != 3, online_selected_flag);
         cond(i, 1'b0);
         tick(3);
         chk("busy_clear", 0, busy);
      end
      // board switch stands in for a low entry enable
      @(posedge ref_clk);
      entry_enable_in_n <= 1'b1;
      sw_entry_force <= 1'b1;
      xfer(8'hc3);
      chk("rx_forced", 8'hc3, last_rx);
      @(posedge ref_clk);
      sw_entry_force <= 1'b0;
      entry_enable_in_n <= 1'b0;
      // request low, request high, switch forced
      for (int i = 0; i < 3; i++) begin
         k0 = n_adv;
         @(posedge ref_clk);
         auto_line_advance_req_n <= (i != 0);
         sw_auto_lf_force <= (i == 2);
         line_done <= 1'b1;
         @(posedge ref_clk);
         line_done <= 1'b0;
         tick(3);
         chk("line_adv", i != 1, n_adv - k0);
      end
      @(posedge ref_clk);
      init_n <= 1'b0;
      repeat (INIT - 3) @(posedge ref_clk);
      init_n <= 1'b1;
      tick(3);
      chk("init_short", 0, n_clr);
      @(posedge ref_clk);
      init_n <= 1'b0;
      repeat (INIT + 3) @(posedge ref_clk);
      init_n <= 1'b1;
      tick(3);
      chk("init_long", 1, n_clr);
      xfer(8'h77);
      chk("rx_after_init", 8'h77, last_rx);
      rd(ppip_pkg::REG_RXDATA);
      chk("rxdata_reg", 32'h77, rv);
      rd(ppip_pkg::REG_STATUS);
      chk("status_reg", (32'h1 << ppip_pkg::ST_ONLINE) | (32'h1 << ppip_pkg::ST_ENTRY_OK) |
          (32'h1 << ppip_pkg::ST_LF_ACTIVE), rv);
      rd(ppip_pkg::REG_INT_STAT);
      chk("int_stat", (32'h1 << ppip_pkg::EV_W) - 32'h1, rv);
      summarize();
   end
endmodule
`default_nettype wire
